//--- inc/pesd_pkg.sv
package pesd_pkg;

  // ----------------------------------------------------------------
  // Event selection codes
  // ----------------------------------------------------------------
  localparam logic [7:0] PESD_EVT_UNHALTED = 8'h79;
  localparam logic [7:0] PESD_EVT_PARTIAL_STALL = 8'hD2;
  localparam logic [7:0] PESD_EVT_SEG_LOAD = 8'h06;
  localparam logic [7:0] PESD_EVT_RESOURCE_STALL = 8'hA2;
  localparam logic [7:0] PESD_EVT_SIMD_EXEC = 8'hB0;
  localparam logic [7:0] PESD_EVT_SIMD_SAT = 8'hB1;
  localparam logic [7:0] PESD_EVT_SIMD_UOP = 8'hB2;
  localparam logic [7:0] PESD_EVT_SIMD_CLASS = 8'hB3;
  localparam logic [7:0] PESD_EVT_SIMD_FP_SWITCH = 8'hCC;
  localparam logic [7:0] PESD_EVT_SIMD_ASSIST = 8'hCD;
  localparam logic [7:0] PESD_EVT_SIMD_RETIRE = 8'hCE;
  localparam logic [7:0] PESD_EVT_SEG_RENAME_STALL = 8'hD4;
  localparam logic [7:0] PESD_EVT_SEG_RENAME = 8'hD5;
  localparam logic [7:0] PESD_EVT_RET_SEG_RENAME = 8'hD6;

  // ----------------------------------------------------------------
  // Qualifier values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] PESD_QUAL_NONE = 8'h00;
  localparam logic [7:0] PESD_QUAL_ALL_SEG = 8'h0F;
  localparam logic [3:0] PESD_QUAL_UOP_NIBBLE = 4'hF;
  localparam logic [7:0] PESD_QUAL_SIMD_TO_FP = 8'h00;
  localparam logic [7:0] PESD_QUAL_FP_TO_SIMD = 8'h01;
  localparam int PESD_CLASS_W = 6;
  localparam int PESD_SEG_W = 4;
  localparam int PESD_STATE_W = 4;
  localparam int PESD_STATE_M = 3;
  localparam int PESD_STATE_E = 2;
  localparam int PESD_STATE_S = 1;
  localparam int PESD_STATE_I = 0;
  localparam int PESD_BUS_ANY_BIT = 5;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  localparam int PESD_COUNT_W = 40;
  localparam logic PESD_HIT_RESET = 1'b0;

  function automatic logic pesd_any(input logic [7:0] a, input logic [7:0] b);
    return |(a & b);
  endfunction

endpackage

//--- inc/pesd_evt_if.sv
`timescale 1ns/1ps
interface pesd_evt_if;
  import pesd_pkg::*;
  logic [7:0] sel_code;
  logic [7:0] sel_qual;
  logic cache_event;
  logic [7:0] cache_code;
  logic [PESD_STATE_W-1:0] cache_state;
  logic bus_event;
  logic [7:0] bus_code;
  logic bus_self;
  logic ext_hit;
  logic count_hit;

  modport qual (
    input sel_code,
    input sel_qual,
    input cache_event,
    input cache_code,
    input cache_state,
    input bus_event,
    input bus_code,
    input bus_self,
    output ext_hit
  );

  modport count (
    input count_hit
  );
endinterface

//--- src/pesd_ext_qual.sv
`timescale 1ns/1ps
module pesd_ext_qual
  import pesd_pkg::*;
(
  pesd_evt_if.qual evt
);

  logic cache_hit;
  logic bus_hit;

  // Low nibble selects line states; a zero nibble never counts
  always_comb begin
    cache_hit = evt.cache_event && (evt.cache_code == evt.sel_code) &&
                pesd_any({4'h0, evt.sel_qual[PESD_STATE_W-1:0]}, {4'h0, evt.cache_state});
  end

  // Clear origin bit keeps only our own transactions
  always_comb begin
    bus_hit = evt.bus_event && (evt.bus_code == evt.sel_code) &&
              (evt.sel_qual[PESD_BUS_ANY_BIT] || evt.bus_self);
  end

  assign evt.ext_hit = cache_hit || bus_hit;

endmodule

//--- src/pesd_counter.sv
`timescale 1ns/1ps
module pesd_counter
  import pesd_pkg::*;
#(
  parameter int COUNT_W = PESD_COUNT_W
)(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_count_clear,
  pesd_evt_if.count evt,
  // Count
  output logic [COUNT_W-1:0] o_count
);

  // Hit in the clear cycle still lands as the first count
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_count <= '0;
    end else if (i_count_clear) begin
      o_count <= {{(COUNT_W-1){1'b0}}, evt.count_hit};
    end else if (evt.count_hit) begin
      o_count <= o_count + {{(COUNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

//--- src/perf_event_select_decode.sv
`timescale 1ns/1ps
module perf_event_select_decode
  import pesd_pkg::*;
#(
  parameter int COUNT_W = PESD_COUNT_W
)(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Selection and control
  input wire logic [7:0] i_event_code,
  input wire logic [7:0] i_event_qualifier,
  input wire logic i_count_clear,
  // Core pipeline sources
  input wire logic i_core_halted,
  input wire logic i_partial_stall,
  input wire logic i_segment_load,
  input wire logic i_stall_rename_buf,
  input wire logic i_stall_mem_buf,
  input wire logic i_stall_mispredict,
  input wire logic i_stall_store_drain,
  input wire logic i_stall_bus_queue,
  input wire logic i_stall_cache_miss,
  // SIMD unit sources
  input wire logic i_simd_exec,
  input wire logic i_simd_move_store,
  input wire logic i_simd_saturating,
  input wire logic i_simd_uop,
  input wire logic [PESD_CLASS_W-1:0] i_simd_class,
  input wire logic i_simd_to_fp,
  input wire logic i_fp_to_simd,
  input wire logic i_simd_state_clear,
  input wire logic i_simd_retire,
  // Segment rename sources
  input wire logic [PESD_SEG_W-1:0] i_seg_rename_stall,
  input wire logic [PESD_SEG_W-1:0] i_seg_rename,
  input wire logic i_retired_seg_rename,
  // Cache sources
  input wire logic i_cache_event,
  input wire logic [7:0] i_cache_event_code,
  input wire logic [PESD_STATE_W-1:0] i_cache_line_state,
  // Bus sources
  input wire logic i_bus_event,
  input wire logic [7:0] i_bus_event_code,
  input wire logic i_bus_self,
  // Results
  output logic o_event_hit,
  output logic [COUNT_W-1:0] o_count
);

  // ----------------------------------------------------------------
  // Shared signals
  // ----------------------------------------------------------------
  pesd_evt_if evt ();

  logic qual_zero;
  logic resource_stall;
  logic core_hit;
  logic next_event_hit;

  assign evt.sel_code = i_event_code;
  assign evt.sel_qual = i_event_qualifier;
  assign evt.cache_event = i_cache_event;
  assign evt.cache_code = i_cache_event_code;
  assign evt.cache_state = i_cache_line_state;
  assign evt.bus_event = i_bus_event;
  assign evt.bus_code = i_bus_event_code;
  assign evt.bus_self = i_bus_self;

  assign qual_zero = (i_event_qualifier == PESD_QUAL_NONE);

  // Bus-queue and cache-miss stalls are inputs but deliberately left out of resource_stall here
  assign resource_stall = i_stall_rename_buf || i_stall_mem_buf ||
                          i_stall_mispredict || i_stall_store_drain;

  // ----------------------------------------------------------------
  // Core event decode
  // ----------------------------------------------------------------
  always_comb begin
    core_hit = 1'b0;
    case (i_event_code)
      PESD_EVT_UNHALTED: begin
        core_hit = qual_zero && !i_core_halted;
      end
      PESD_EVT_PARTIAL_STALL: begin
        core_hit = qual_zero && i_partial_stall;
      end
      PESD_EVT_SEG_LOAD: begin
        core_hit = qual_zero && i_segment_load;
      end
      PESD_EVT_RESOURCE_STALL: begin
        core_hit = qual_zero && resource_stall;
      end
      PESD_EVT_SIMD_EXEC: begin
        core_hit = qual_zero && i_simd_exec && !i_simd_move_store;
      end
      PESD_EVT_SIMD_SAT: begin
        core_hit = qual_zero && i_simd_exec && i_simd_saturating;
      end
      PESD_EVT_SIMD_UOP: begin
        core_hit = (i_event_qualifier[3:0] == PESD_QUAL_UOP_NIBBLE) && i_simd_uop;
      end
      PESD_EVT_SIMD_CLASS: begin
        core_hit = pesd_any({2'b00, i_event_qualifier[PESD_CLASS_W-1:0]}, {2'b00, i_simd_class});
      end
      PESD_EVT_SIMD_FP_SWITCH: begin
        if (i_event_qualifier == PESD_QUAL_SIMD_TO_FP) begin
          core_hit = i_simd_to_fp;
        end else if (i_event_qualifier == PESD_QUAL_FP_TO_SIMD) begin
          core_hit = i_fp_to_simd;
        end else begin
          core_hit = 1'b0;
        end
      end
      PESD_EVT_SIMD_ASSIST: begin
        core_hit = qual_zero && i_simd_state_clear;
      end
      PESD_EVT_SIMD_RETIRE: begin
        core_hit = qual_zero && i_simd_retire;
      end
      PESD_EVT_SEG_RENAME_STALL: begin
        // Stall masks sit one bit up: 02H first segment, 08H third
        if (i_event_qualifier == PESD_QUAL_ALL_SEG) begin
          core_hit = |i_seg_rename_stall;
        end else begin
          core_hit = pesd_any({5'h00, i_event_qualifier[3:1]}, {5'h00, i_seg_rename_stall[2:0]});
        end
      end
      PESD_EVT_SEG_RENAME: begin
        if (i_event_qualifier == PESD_QUAL_ALL_SEG) begin
          core_hit = |i_seg_rename;
        end else begin
          core_hit = pesd_any({4'h0, i_event_qualifier[3:0]}, {4'h0, i_seg_rename});
        end
      end
      PESD_EVT_RET_SEG_RENAME: begin
        core_hit = qual_zero && i_retired_seg_rename;
      end
      default: begin
        core_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Cache and bus qualification, accumulation
  // ----------------------------------------------------------------
  pesd_ext_qual u_ext_qual (
    .evt (evt.qual)
  );

  assign next_event_hit = core_hit || evt.ext_hit;
  assign evt.count_hit = next_event_hit;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_event_hit <= PESD_HIT_RESET;
    end else begin
      o_event_hit <= next_event_hit;
    end
  end

  pesd_counter #(
    .COUNT_W (COUNT_W)
  ) u_counter (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_count_clear (i_count_clear),
    .evt (evt.count),
    .o_count (o_count)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_unhalted;
    (i_event_code == PESD_EVT_UNHALTED) && qual_zero |=> (o_event_hit == !$past(i_core_halted));
  endproperty
  a_unhalted: assert property (p_unhalted) else $error("unhalted cycle miscounted");

  property p_seg_load;
    (i_event_code == PESD_EVT_SEG_LOAD) && qual_zero && i_segment_load |=> o_event_hit;
  endproperty
  a_seg_load: assert property (p_seg_load) else $error("segment load not counted");

  property p_resource_excluded;
    (i_event_code == PESD_EVT_RESOURCE_STALL) && !resource_stall && (i_stall_bus_queue || i_stall_cache_miss)
      |=> !o_event_hit;
  endproperty
  a_resource_excluded: assert property (p_resource_excluded) else $error("excluded stall counted");

  property p_resource_included;
    (i_event_code == PESD_EVT_RESOURCE_STALL) && qual_zero && (i_stall_mispredict || i_stall_rename_buf)
      |=> o_event_hit;
  endproperty
  a_resource_included: assert property (p_resource_included) else $error("resource stall missed");

  property p_simd_move_store;
    (i_event_code == PESD_EVT_SIMD_EXEC) && i_simd_move_store |=> !o_event_hit;
  endproperty
  a_simd_move_store: assert property (p_simd_move_store) else $error("move store counted");

  property p_simd_class;
    (i_event_code == PESD_EVT_SIMD_CLASS) |=>
      (o_event_hit == |($past(i_event_qualifier[PESD_CLASS_W-1:0]) & $past(i_simd_class)));
  endproperty
  a_simd_class: assert property (p_simd_class) else $error("class select wrong");

  property p_fp_switch;
    (i_event_code == PESD_EVT_SIMD_FP_SWITCH) && (i_event_qualifier == PESD_QUAL_FP_TO_SIMD) && !i_fp_to_simd
      |=> !o_event_hit;
  endproperty
  a_fp_switch: assert property (p_fp_switch) else $error("wrong switch direction counted");

  property p_seg_stall_all;
    (i_event_code == PESD_EVT_SEG_RENAME_STALL) && (i_event_qualifier == PESD_QUAL_ALL_SEG) &&
      i_seg_rename_stall[PESD_SEG_W-1] |=> o_event_hit;
  endproperty
  a_seg_stall_all: assert property (p_seg_stall_all) else $error("all-segment stall missed");

  property p_cache_zero_qual;
    i_cache_event && (i_cache_event_code == i_event_code) && (i_event_qualifier[3:0] == 4'h0) && !core_hit
      && !(i_bus_event && (i_bus_event_code == i_event_code)) |=> !o_event_hit;
  endproperty
  a_cache_zero_qual: assert property (p_cache_zero_qual) else $error("zero state qualifier counted");

  property p_bus_foreign;
    i_bus_event && (i_bus_event_code == i_event_code) && !i_bus_self && !i_event_qualifier[PESD_BUS_ANY_BIT]
      && !core_hit && !i_cache_event |=> !o_event_hit;
  endproperty
  a_bus_foreign: assert property (p_bus_foreign) else $error("foreign transaction counted");

  property p_count_step;
    !$past(i_count_clear) |-> (o_count == $past(o_count) + (o_event_hit ? 1 : 0));
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_count_clear;
    $past(i_count_clear) |-> (o_count == COUNT_W'(o_event_hit));
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("clear lost a hit");

  property p_partial_stall;
    (i_event_code == PESD_EVT_PARTIAL_STALL) && qual_zero && i_partial_stall |=> o_event_hit;
  endproperty
  a_partial_stall: assert property (p_partial_stall) else $error("partial stall not counted");

  property p_resource_drain;
    (i_event_code == PESD_EVT_RESOURCE_STALL) && qual_zero && (i_stall_store_drain || i_stall_mem_buf)
      |=> o_event_hit;
  endproperty
  a_resource_drain: assert property (p_resource_drain) else $error("drain stall missed");

  property p_simd_exec;
    (i_event_code == PESD_EVT_SIMD_EXEC) && qual_zero && i_simd_exec && !i_simd_move_store |=> o_event_hit;
  endproperty
  a_simd_exec: assert property (p_simd_exec) else $error("simd execute missed");

  property p_simd_sat;
    (i_event_code == PESD_EVT_SIMD_SAT) && qual_zero && i_simd_exec && i_simd_saturating |=> o_event_hit;
  endproperty
  a_simd_sat: assert property (p_simd_sat) else $error("saturating op missed");

  property p_simd_uop;
    (i_event_code == PESD_EVT_SIMD_UOP) && (i_event_qualifier[3:0] == PESD_QUAL_UOP_NIBBLE) && i_simd_uop |=> o_event_hit;
  endproperty
  a_simd_uop: assert property (p_simd_uop) else $error("micro-op missed");

  property p_fp_to_simd;
    (i_event_code == PESD_EVT_SIMD_FP_SWITCH) && (i_event_qualifier == PESD_QUAL_FP_TO_SIMD) && i_fp_to_simd
      |=> o_event_hit;
  endproperty
  a_fp_to_simd: assert property (p_fp_to_simd) else $error("switch to simd missed");

  property p_simd_assist;
    (i_event_code == PESD_EVT_SIMD_ASSIST) && qual_zero && i_simd_state_clear |=> o_event_hit;
  endproperty
  a_simd_assist: assert property (p_simd_assist) else $error("state clear missed");

  property p_simd_retire;
    (i_event_code == PESD_EVT_SIMD_RETIRE) && qual_zero && i_simd_retire |=> o_event_hit;
  endproperty
  a_simd_retire: assert property (p_simd_retire) else $error("simd retire missed");

  property p_seg_stall_one;
    (i_event_code == PESD_EVT_SEG_RENAME_STALL) && i_event_qualifier[1] && i_seg_rename_stall[0] |=> o_event_hit;
  endproperty
  a_seg_stall_one: assert property (p_seg_stall_one) else $error("first segment stall missed");

  property p_seg_rename;
    (i_event_code == PESD_EVT_SEG_RENAME) && |(i_event_qualifier[3:0] & i_seg_rename) |=> o_event_hit;
  endproperty
  a_seg_rename: assert property (p_seg_rename) else $error("segment rename missed");

  property p_seg_rename_all;
    (i_event_code == PESD_EVT_SEG_RENAME) && (i_event_qualifier == PESD_QUAL_ALL_SEG) &&
      i_seg_rename[PESD_SEG_W-1] |=> o_event_hit;
  endproperty
  a_seg_rename_all: assert property (p_seg_rename_all) else $error("all-segment rename missed");

  property p_ret_seg_rename;
    (i_event_code == PESD_EVT_RET_SEG_RENAME) && qual_zero && i_retired_seg_rename |=> o_event_hit;
  endproperty
  a_ret_seg_rename: assert property (p_ret_seg_rename) else $error("retired rename missed");

  property p_cache_modified;
    i_cache_event && (i_cache_event_code == i_event_code) && i_event_qualifier[PESD_STATE_M] &&
      i_cache_line_state[PESD_STATE_M] |=> o_event_hit;
  endproperty
  a_cache_modified: assert property (p_cache_modified) else $error("modified line missed");

  property p_cache_invalid;
    i_cache_event && (i_cache_event_code == i_event_code) && i_event_qualifier[PESD_STATE_I] &&
      i_cache_line_state[PESD_STATE_I] |=> o_event_hit;
  endproperty
  a_cache_invalid: assert property (p_cache_invalid) else $error("invalid line missed");

  property p_bus_any;
    i_bus_event && (i_bus_event_code == i_event_code) && i_event_qualifier[PESD_BUS_ANY_BIT] |=> o_event_hit;
  endproperty
  a_bus_any: assert property (p_bus_any) else $error("any-origin transaction missed");

  c_unhalted_run: cover property ((i_event_code == PESD_EVT_UNHALTED) && qual_zero ##1 o_event_hit [*3]);
  c_cache_hit: cover property (i_cache_event && (i_cache_event_code == i_event_code) ##1 o_event_hit);
  c_bus_any: cover property (i_bus_event && !i_bus_self && i_event_qualifier[PESD_BUS_ANY_BIT] ##1 o_event_hit);
  c_clear_hit: cover property (i_count_clear && next_event_hit);
  c_seg_rename_all: cover property ((i_event_code == PESD_EVT_SEG_RENAME) &&
    (i_event_qualifier == PESD_QUAL_ALL_SEG) ##1 o_event_hit);

endmodule

//--- tb/pesd_src_model.sv
`timescale 1ns/1ps
module pesd_src_model (
  // Clock and random draw
  input wire logic i_sys_clk,
  input wire logic [63:0] i_draw,
  // Occurrence groups
  output logic [8:0] o_core,
  output logic [13:0] o_simd,
  output logic [8:0] o_seg,
  output logic [12:0] o_cache,
  output logic [9:0] o_bus
);
  // ----------------------------------------------------------------
  // Source occurrences, launched just after each edge
  // ----------------------------------------------------------------
  // Qualifying flags only ever ride on an executed instruction
  always @(posedge i_sys_clk) begin
    o_core <= i_draw[8:0];
    o_simd[0] <= i_draw[10];
    o_simd[1] <= i_draw[10] & i_draw[11];
    o_simd[2] <= i_draw[10] & i_draw[12];
    o_simd[3] <= i_draw[13];
    o_simd[9:4] <= (i_draw[14] && i_draw[17:15] < 3'h6) ? 6'h01 << i_draw[17:15] : 6'h00;
    o_simd[13:10] <= i_draw[21:18];
    o_seg <= i_draw[30:22];
    // Cache and bus codes kept apart from the fixed codes
    o_cache <= {i_draw[36:33], i_draw[32] ? 8'h2E : 8'h29, i_draw[31]};
    o_bus <= {i_draw[39], i_draw[38] ? 8'h62 : 8'h6A, i_draw[37]};
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import pesd_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] code = 8'h00;
  logic [7:0] qual = 8'h00;
  logic clear = 1'b0;
  logic [63:0] draw = 64'h0;
  logic [8:0] core;
  logic [13:0] simd;
  logic [8:0] seg;
  logic [12:0] cache;
  logic [9:0] bus;
  logic o_event_hit;
  logic [PESD_COUNT_W-1:0] o_count;
  logic exp_hit = 1'b0;
  logic [PESD_COUNT_W-1:0] exp_count = '0;
  int failures = 0;
  int n_checks = 0;
  int seed = 32'h601b;
  logic [7:0] codes [17] = '{8'h79, 8'hD2, 8'h06, 8'hA2, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hCC,
                             8'hCD, 8'hCE, 8'hD4, 8'hD5, 8'hD6, 8'h2E, 8'h62, 8'h55};
  logic [7:0] quals [11] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0F, 8'h10, 8'h20, 8'h2F, 8'h0E, 8'h3F};

  always #20 i_sys_clk = ~i_sys_clk;

  pesd_src_model src (.i_sys_clk(i_sys_clk), .i_draw(draw), .o_core(core), .o_simd(simd),
                      .o_seg(seg), .o_cache(cache), .o_bus(bus));

  perf_event_select_decode uut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_event_code(code), .i_event_qualifier(qual),
    .i_count_clear(clear), .i_core_halted(core[0]), .i_partial_stall(core[1]),
    .i_segment_load(core[2]), .i_stall_rename_buf(core[3]), .i_stall_mem_buf(core[4]),
    .i_stall_mispredict(core[5]), .i_stall_store_drain(core[6]), .i_stall_bus_queue(core[7]),
    .i_stall_cache_miss(core[8]), .i_simd_exec(simd[0]), .i_simd_move_store(simd[1]),
    .i_simd_saturating(simd[2]), .i_simd_uop(simd[3]), .i_simd_class(simd[9:4]),
    .i_simd_to_fp(simd[10]), .i_fp_to_simd(simd[11]), .i_simd_state_clear(simd[12]),
    .i_simd_retire(simd[13]), .i_seg_rename_stall(seg[3:0]), .i_seg_rename(seg[7:4]),
    .i_retired_seg_rename(seg[8]), .i_cache_event(cache[0]), .i_cache_event_code(cache[8:1]),
    .i_cache_line_state(cache[12:9]), .i_bus_event(bus[0]), .i_bus_event_code(bus[8:1]),
    .i_bus_self(bus[9]), .o_event_hit(o_event_hit), .o_count(o_count));

  // ----------------------------------------------------------------
  // Expected behaviour
  // ----------------------------------------------------------------
  function automatic logic ref_hit(input logic [7:0] c, input logic [7:0] q);
    logic h;
    logic z;
    z = (q == 8'h00);
    case (c)
      PESD_EVT_UNHALTED: h = z && !core[0];
      PESD_EVT_PARTIAL_STALL: h = z && core[1];
      PESD_EVT_SEG_LOAD: h = z && core[2];
      PESD_EVT_RESOURCE_STALL: h = z && |core[6:3];
      PESD_EVT_SIMD_EXEC: h = z && simd[0] && !simd[1];
      PESD_EVT_SIMD_SAT: h = z && simd[0] && simd[2];
      PESD_EVT_SIMD_UOP: h = (q[3:0] == 4'hF) && simd[3];
      PESD_EVT_SIMD_CLASS: h = |(q[5:0] & simd[9:4]);
      PESD_EVT_SIMD_FP_SWITCH: h = z ? simd[10] : (q == 8'h01) && simd[11];
      PESD_EVT_SIMD_ASSIST: h = z && simd[12];
      PESD_EVT_SIMD_RETIRE: h = z && simd[13];
      PESD_EVT_SEG_RENAME_STALL: h = (q == 8'h0F) ? |seg[3:0] : |(q[3:1] & seg[2:0]);
      PESD_EVT_SEG_RENAME: h = (q == 8'h0F) ? |seg[7:4] : |(q[3:0] & seg[7:4]);
      PESD_EVT_RET_SEG_RENAME: h = z && seg[8];
      default: h = 1'b0;
    endcase
    if (cache[0] && cache[8:1] == c && |(q[3:0] & cache[12:9])) h = 1'b1;
    if (bus[0] && bus[8:1] == c && (q[5] || bus[9])) h = 1'b1;
    return h;
  endfunction

  // Worked out at the edge itself, before the new drive lands
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      exp_hit <= 1'b0;
      exp_count <= '0;
    end else begin
      exp_hit <= ref_hit(code, qual);
      exp_count <= (clear ? '0 : exp_count) + {{(PESD_COUNT_W-1){1'b0}}, ref_hit(code, qual)};
    end
  end

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic check_hit(input logic got, input logic want);
    n_checks++;
    if (got !== want) begin
      failures++;
      $display("unexpected at %0t: hit %b, wanted %b, code %h qual %h", $time, got, want, code, qual);
    end
  endtask

  task automatic check_count(input logic [PESD_COUNT_W-1:0] got, input logic [PESD_COUNT_W-1:0] want);
    n_checks++;
    if (got !== want) begin
      failures++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, want);
    end
  endtask

  always @(negedge i_sys_clk) begin
    check_hit(o_event_hit, exp_hit);
    check_count(o_count, exp_count);
  end

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic run(input logic [7:0] c, input logic [7:0] q, input logic clr, input int n);
    @(posedge i_sys_clk);
    code <= c;
    qual <= q;
    clear <= clr;
    draw <= {$random(seed), $random(seed)};
    repeat (n - 1) begin
      @(posedge i_sys_clk);
      clear <= 1'b0;
      draw <= {$random(seed), $random(seed)};
    end
  endtask

  initial begin
    #(40 * 20000);
    failures++;
    wrap_up();
  end

  initial begin
    int r;
    repeat (20) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    // Every code against the boundary qualifiers, zero state mask included
    foreach (codes[i]) foreach (quals[j]) run(codes[i], quals[j], 1'b0, 6);
    $display("test corner_qualifiers done");
    // Reset in mid-count, then counting resumes from zero
    run(PESD_EVT_UNHALTED, 8'h00, 1'b0, 5);
    i_reset_n <= 1'b0;
    run(PESD_EVT_UNHALTED, 8'h00, 1'b0, 3);
    i_reset_n <= 1'b1;
    run(PESD_EVT_UNHALTED, 8'h00, 1'b1, 8);
    $display("test midrun_reset done");
    // Random selections with occasional clears, hit or not
    repeat (2500) begin
      r = $random(seed);
      run(codes[$unsigned(r) % 17], quals[$unsigned(r >>> 8) % 11], r[20:17] == 4'h0, 1 + $unsigned(r >>> 24) % 3);
    end
    $display("test random_mix done");
    run(8'h55, 8'h00, 1'b0, 3);
    wrap_up();
  end
endmodule
